/* File: shared/otp_sec_pkg.sv */
package otp_sec_pkg;

   // =====================================================================
   // security word bit positions
   localparam int SEC_NO_TEST_PORT = 0;
   localparam int SEC_NO_LINK = 1;
   localparam int SEC_OTP_BOOT = 5;
   localparam int SEC_REDUNDANT = 7;
   localparam int SEC_SECTOR_LOCK_LO = 8;
   localparam int SEC_MASTER_LOCK = 12;
   localparam int SEC_NO_TEST_OTP = 13;
   localparam int SEC_NO_SYNC_PIN = 14;
   localparam int SEC_GP_LO = 15;
   localparam int SEC_GP_HI = 21;
   localparam int SEC_UID_LO = 22;
   localparam int SEC_UID_HI = 31;
   // bits that have a function; 2..4 and 6 read as zero
   localparam logic [31:0] SEC_DEFINED_MASK = 32'hFFFF_FFA3;

   // =====================================================================
   // memory organisation
   localparam int OTP_SECTORS = 4;
   localparam int OTP_ROWS = 512;
   localparam int OTP_ADDR_W = 11;
   localparam logic [10:0] OTP_SEC_ROW = 11'h7FF; // security word row
   localparam logic [10:0] OTP_BOOT_ROW = 11'h000;
   localparam logic [10:0] OTP_LAST_ROW = 11'h7FE;

   // =====================================================================
   // programming ports and resource identifiers
   localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
   localparam logic [23:0] RES_OTP_DATA = 24'h200100;
   localparam logic [23:0] RES_OTP_CTRL = 24'h100300;
   localparam int CTRL_PROG_BIT = 0;
   localparam int CTRL_SEC_BIT = 1; // target the security word

   // =====================================================================
   // test port
   localparam int IR_W = 4;
   localparam int DR_W = 32;
   localparam logic [3:0] IR_DEVICE_IDENTIFICATION = 4'h1;
   localparam logic [3:0] IR_USERCODE = 4'h2;
   localparam logic [3:0] IR_OTP_ACCESS = 4'h3;
   localparam logic [3:0] IR_TILE = 4'h4;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   // identity fields: values are arbitrary
   localparam logic [3:0] ID_VERSION = 4'h0;
   localparam logic [15:0] ID_PART = 16'h0001;
   localparam logic [10:0] ID_MAKER = 11'h001;
   localparam logic [3:0] SI_REVISION = 4'h1;

   typedef enum logic [1:0] {ST_LOAD_SEC, ST_PRELOAD, ST_RUN} boot_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] data;
      logic [15:0] ctrl;
   } prog_s;

   typedef struct packed {
      logic test_port_off;
      logic link_off;
      logic boot_otp;
      logic redundant;
      logic otp_test_off;
      logic sync_pin_off;
   } gate_s;

endpackage

/* File: logic/otp_security.sv */
`timescale 1ns/1ns
// Contract
// - bit 0 blocks test-port tile access
// - bit 1 blocks switch access to state
// - bit 5 boots from OTP row zero
// - bit 7 enables redundant OTP rows
// - bits 8-11 lock sectors 0-3
// - bit 12 blocks all further programming
// - bit 13 blocks test-port OTP access
// - bit 14 disables debug sync pin
// - bits 15-21 software readable field
// - usercode id from bits 22-31
// - four sectors of 512 32-bit rows
// - security word loaded at power up
// - remaining OTP copied to SRAM first
// - address, data, control programming ports
// - DEVICE_IDENTIFICATION word, bit 0 one
// - USERCODE: user id, unused, revision
// - output mode drives pin on breakpoint
// - input mode low enters debug
module otp_security
(
   // system
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // programming ports
   input wire otp_sec_pkg::prog_s i_prog,
   input wire logic i_prog_strobe,
   output logic o_prog_refused,
   // test port (pins)
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   input wire logic i_trst_n,
   output logic o_tdo,
   output logic o_tile_sel,
   // switch request for processor state
   input wire logic i_link_req,
   output logic o_link_grant,
   // debug sync pin and processor
   input wire logic i_sync_in,
   output logic o_sync_out,
   output logic o_sync_oe_n,
   input wire logic i_sync_out_mode,
   input wire logic i_sync_in_mode,
   input wire logic i_breakpoint,
   output logic o_enter_debug,
   // preload to SRAM and boot
   output logic o_sram_we,
   output logic [10:0] o_sram_addr,
   output logic [31:0] o_sram_data,
   output logic o_boot_ready,
   output logic o_boot_from_otp,
   output logic o_redundant_rows,
   // software view
   output logic [31:0] o_sec_word,
   output logic [6:0] o_gp_field
);
   import otp_sec_pkg::*;

   // =====================================================================
   // state
   typedef struct packed {
      boot_e st;
      logic [10:0] row;
      logic [31:0] sec;
      logic [2:0] tck_s;
      logic [1:0] tms_s;
      logic [1:0] tdi_s;
      logic [1:0] trst_s;
      logic [1:0] sync_s;
      logic [3:0] tap;
      logic [3:0] ir;
      logic [31:0] dr;
      logic tdo;
      logic refused;
      logic we;
      logic [10:0] waddr;
      logic [31:0] wdata;
      logic sync_low;
      logic dbg;
      logic grant;
   } state_s;

   state_s s_q, s_d;
   // two-state so a never-written row reads zero, as on a blank part
   bit [31:0] otp_mem [0:OTP_SECTORS*OTP_ROWS-1]; // storage
   logic [31:0] rd_q;
   logic [10:0] rd_addr;
   logic prog_go;
   logic [1:0] prog_sector;
   logic tck_rise;
   logic [31:0] uid_word;
   logic [31:0] id_word;

   // =====================================================================
   // array: written only by accepted programming, read one row per cycle
   always_ff @(posedge i_clk_sys)
   begin
      if (prog_go)
      begin
         otp_mem[i_prog.ctrl[CTRL_SEC_BIT] ? OTP_SEC_ROW : i_prog.addr[OTP_ADDR_W-1:0]]
            <= i_prog.data;
      end
      rd_q <= otp_mem[rd_addr];
   end

   // read the security row while reset is held, so that the word already
   // stands on rd_q when the load state runs in the first cycle after it
   assign rd_addr = i_rst_n ? s_d.row : OTP_SEC_ROW;

   // programming gate; sector index is the top two address bits
   assign prog_sector = i_prog.addr[OTP_ADDR_W-1:OTP_ADDR_W-2];
   assign prog_go = i_prog_strobe && i_prog.ctrl[CTRL_PROG_BIT] && (s_q.st == ST_RUN)
      && !s_q.sec[SEC_MASTER_LOCK]
      && (i_prog.ctrl[CTRL_SEC_BIT] || !s_q.sec[SEC_SECTOR_LOCK_LO + prog_sector]);

   // identity words
   // device_identification layout
   assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
   assign uid_word = {s_q.sec[SEC_UID_HI:SEC_UID_LO], 18'h00000, SI_REVISION};

   assign tck_rise = s_q.tck_s[1] && !s_q.tck_s[2];

   // =====================================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      // pins pass two flops before use; stage 0 only feeds stage 1
      s_d.tck_s = {s_q.tck_s[1:0], i_tck};
      s_d.tms_s = {s_q.tms_s[0], i_tms};
      s_d.tdi_s = {s_q.tdi_s[0], i_tdi};
      s_d.trst_s = {s_q.trst_s[0], i_trst_n};
      s_d.sync_s = {s_q.sync_s[0], i_sync_in};
      s_d.we = 1'b0;
      s_d.refused = i_prog_strobe && i_prog.ctrl[CTRL_PROG_BIT] && !prog_go;

      // boot sequence
      case (s_q.st)
         ST_LOAD_SEC:
         begin
            s_d.sec = rd_q & SEC_DEFINED_MASK;
            s_d.row = OTP_BOOT_ROW;
            s_d.st = ST_PRELOAD;
         end
         ST_PRELOAD:
         begin
            // copy to SRAM; start at row zero
            s_d.we = 1'b1;
            s_d.waddr = s_q.row;
            s_d.wdata = rd_q;
            if (s_q.row == OTP_LAST_ROW)
            begin
               s_d.st = ST_RUN;
            end
            else
            begin
               s_d.row = s_q.row + 11'h001;
            end
         end
         default:
         begin
            s_d.st = ST_RUN;
         end
      endcase

      // test access port: reduced controller, idle/shift-dr/shift-ir
      if (!s_q.trst_s[1])
      begin
         s_d.tap = 4'h0;
         s_d.ir = IR_DEVICE_IDENTIFICATION;
         s_d.dr = id_word;
      end
      else if (tck_rise)
      begin
         case (s_q.tap)
            4'h0:
            begin
               s_d.tap = s_q.tms_s[1] ? 4'h1 : 4'h0;
            end
            4'h1:
            begin
               s_d.tap = s_q.tms_s[1] ? 4'h2 : 4'h3;
               s_d.dr = (s_q.ir == IR_USERCODE) ? uid_word : id_word;
               // otp read from test port only while bit 13 is clear
               if (s_q.ir == IR_OTP_ACCESS)
               begin
                  // loaded word, not the array port, which the preload leaves parked
                  s_d.dr = s_q.sec[SEC_NO_TEST_OTP] ? 32'h0000_0000 : s_q.sec;
               end
            end
            4'h2:
            begin
               s_d.tap = s_q.tms_s[1] ? 4'h0 : 4'h4;
            end
            4'h3:
            begin
               s_d.tdo = s_q.dr[0];
               s_d.dr = {s_q.tdi_s[1], s_q.dr[DR_W-1:1]};
               s_d.tap = s_q.tms_s[1] ? 4'h0 : 4'h3;
            end
            default:
            begin
               s_d.tdo = s_q.ir[0];
               s_d.ir = {s_q.tdi_s[1], s_q.ir[IR_W-1:1]};
               s_d.tap = s_q.tms_s[1] ? 4'h0 : 4'h4;
            end
         endcase
      end

      s_d.grant = i_link_req && (s_q.st == ST_RUN) && !s_q.sec[SEC_NO_LINK];

      // drive low on breakpoint; pin disabled
      if (s_q.sec[SEC_NO_SYNC_PIN] || !i_sync_out_mode)
      begin
         s_d.sync_low = 1'b0;
      end
      else if (i_breakpoint)
      begin
         s_d.sync_low = 1'b1;
      end
      s_d.dbg = i_sync_in_mode && !s_q.sec[SEC_NO_SYNC_PIN] && !s_q.sync_s[1];
   end

   // =====================================================================
   // registers: security word holds every defined bit set until loaded
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
         s_q.st <= ST_LOAD_SEC;
         s_q.row <= OTP_SEC_ROW;
         s_q.sec <= SEC_DEFINED_MASK; // locked until the real word arrives
         s_q.ir <= IR_DEVICE_IDENTIFICATION;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // =====================================================================
   // outputs
   assign o_prog_refused = s_q.refused;
   assign o_tdo = s_q.tdo;
   assign o_tile_sel = (s_q.ir == IR_TILE) && (s_q.st == ST_RUN) && !s_q.sec[SEC_NO_TEST_PORT];
   assign o_link_grant = s_q.grant;
   assign o_sync_out = 1'b0;
   assign o_sync_oe_n = !s_q.sync_low;
   assign o_enter_debug = s_q.dbg;
   assign o_sram_we = s_q.we;
   assign o_sram_addr = s_q.waddr;
   assign o_sram_data = s_q.wdata;
   assign o_boot_ready = (s_q.st == ST_RUN);
   assign o_boot_from_otp = s_q.sec[SEC_OTP_BOOT] && (s_q.st == ST_RUN);
   assign o_redundant_rows = s_q.sec[SEC_REDUNDANT];
   assign o_sec_word = s_q.sec;
   assign o_gp_field = s_q.sec[SEC_GP_HI:SEC_GP_LO];

   // =====================================================================
   // checks
   // programming locks, judged at the refusal output rather than at the gate
   // itself, so a wrong gate term cannot hide behind its own expression
   a_master_lock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_prog_strobe && i_prog.ctrl[CTRL_PROG_BIT] && s_q.sec[SEC_MASTER_LOCK] |=> o_prog_refused)
      else $error("programming past master lock");
   a_sector_lock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_prog_strobe && i_prog.ctrl[CTRL_PROG_BIT] && !i_prog.ctrl[CTRL_SEC_BIT]
      && s_q.sec[SEC_SECTOR_LOCK_LO + prog_sector] |=> o_prog_refused)
      else $error("locked sector programmed");

   // test port and switch gates
   a_test_port_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_q.sec[SEC_NO_TEST_PORT] |-> !o_tile_sel) else $error("tile reached while disabled");
   a_tile_open: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_q.ir == IR_TILE && o_boot_ready && !o_sec_word[SEC_NO_TEST_PORT] |-> o_tile_sel)
      else $error("tile port not reached");
   // capture is the only path from the security word to the scan chain
   a_otp_test_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_q.trst_s[1] && tck_rise && s_q.tap == 4'h1 && s_q.ir == IR_OTP_ACCESS
      && s_q.sec[SEC_NO_TEST_OTP] |=> s_q.dr == 32'h0000_0000)
      else $error("otp word reached test port");
   a_link_block: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_q.sec[SEC_NO_LINK] |=> !o_link_grant) else $error("link granted while denied");
   a_grant_open: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_link_req && o_boot_ready && !s_q.sec[SEC_NO_LINK] |=> o_link_grant)
      else $error("open link not granted");
   a_link_boot: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_boot_ready |=> !o_link_grant) else $error("link granted before load");

   // debug sync pin
   a_sync_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_q.sec[SEC_NO_SYNC_PIN] |=> o_sync_oe_n && !o_enter_debug)
      else $error("sync pin active while disabled");
   a_sync_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_sync_out_mode && i_breakpoint && !s_q.sec[SEC_NO_SYNC_PIN] |=> !o_sync_oe_n)
      else $error("breakpoint did not pull pin");
   // the pin floats unless output mode is on; a stray drive would fight the pull-up
   a_sync_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_sync_out_mode |=> o_sync_oe_n) else $error("pin driven outside output mode");
   a_debug_enter: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_sync_in_mode && !s_q.sec[SEC_NO_SYNC_PIN] && !s_q.sync_s[1] |=> o_enter_debug)
      else $error("low pin did not enter debug");

   // boot sequence and software view
   a_load_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_boot_ready) |-> $past(s_q.st) == ST_PRELOAD) else $error("run before load");
   a_preload_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      s_q.st == ST_PRELOAD |=> o_sram_we && o_sram_addr == $past(s_q.row))
      else $error("preload word not written");
   a_boot_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_boot_from_otp |-> o_boot_ready && o_sec_word[SEC_OTP_BOOT])
      else $error("otp boot without its bit");
   a_redundant: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_redundant_rows == o_sec_word[SEC_REDUNDANT]) else $error("redundancy mismatch");
   // undefined bits must never leak, even from a word programmed with them set
   a_undef_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_sec_word & ~SEC_DEFINED_MASK) == 32'h0000_0000) else $error("undefined bits set");
   a_gp_field: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_gp_field == o_sec_word[SEC_GP_HI:SEC_GP_LO]) else $error("user field mismatch");
   a_uid_field: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      uid_word[31:22] == o_sec_word[31:22] && id_word[0]) else $error("usercode mismatch");

endmodule

/* File: tb/jtag_probe.sv */
`timescale 1ns/1ns
// ====
// test-port probe model
module jtag_probe
(
   // test pins
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   output logic o_trst_n,
   input wire logic i_tdo
);
   // tck stands still between scans
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b0;
      o_tdi = 1'b0;
      o_trst_n = 1'b0;
      #400 o_trst_n = 1'b1;
   end

   // slow tck so the two-flop synchronisers never miss an edge
   task automatic pulse(input logic tms, input logic tdi);
      o_tms = tms;
      o_tdi = tdi;
      #160 o_tck = 1'b1;
      #160 o_tck = 1'b0;
      o_tdi = ~tdi; // released line shows no stale bit
   endtask

   // instruction scan then a full data scan, lsb first
   task automatic scan(input logic [3:0] ir, output logic [31:0] dr);
      pulse(1'b1, 1'b0);
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b0);
      for (int i = 0; i < 4; i++)
         pulse(i == 3, ir[i]);
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b0);
      for (int i = 0; i < 32; i++)
      begin
         // tdo shows each bit after the rise that shifts it out
         pulse(i == 31, 1'b0);
         dr[i] = i_tdo;
      end
   endtask
endmodule

/* File: tb/tb_otp_security.sv */
`timescale 1ns/1ns
module tb_otp_security;
   import otp_sec_pkg::*;
   // ====
   // stimulus and wires
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   prog_s prog = '0;
   logic strobe = 1'b0;
   logic link_req = 1'b0;
   logic out_mode = 1'b0;
   logic in_mode = 1'b0;
   logic bp = 1'b0;
   logic ext_low = 1'b0;
   logic taken = 1'b0;
   logic refused, tck, tms, tdi, trst_n, tdo, tile_sel, grant;
   logic sync_in, sync_out, oe_n, dbg, we, ready, boot_otp, redun;
   logic [10:0] sram_addr;
   logic [31:0] sram_data, sec_word, word_a, word_b, rd;
   logic [6:0] gp;
   logic exp_q[$];
   bit [31:0] shadow [0:OTP_SECTORS*OTP_ROWS-1];
   int err_count = 0;
   int comparisons = 0;
   int wr_cnt = 0;
   // pull-up on the pin; the far side pulls low in input mode
   assign sync_in = !oe_n ? sync_out : !ext_low;
   always #10 clk_sys = ~clk_sys;

   otp_security dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_prog(prog),
      .i_prog_strobe(strobe), .o_prog_refused(refused), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tile_sel(tile_sel),
      .i_link_req(link_req), .o_link_grant(grant), .i_sync_in(sync_in),
      .o_sync_out(sync_out), .o_sync_oe_n(oe_n), .i_sync_out_mode(out_mode),
      .i_sync_in_mode(in_mode), .i_breakpoint(bp), .o_enter_debug(dbg),
      .o_sram_we(we), .o_sram_addr(sram_addr), .o_sram_data(sram_data),
      .o_boot_ready(ready), .o_boot_from_otp(boot_otp), .o_redundant_rows(redun),
      .o_sec_word(sec_word), .o_gp_field(gp));
   jtag_probe probe (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
      .i_tdo(tdo));

   // ====
   // checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // refusal shows in the cycle after the taking edge; x notes are not judged
   always @(posedge clk_sys)
      taken <= strobe && rst_n;
   always @(negedge clk_sys)
      if (taken && exp_q.size() > 0 && exp_q[0] !== 1'bx)
         chk(refused, exp_q.pop_front());
      else if (taken && exp_q.size() > 0)
         void'(exp_q.pop_front());
   // preload stream: rows in order, each holding what was accepted into it
   always @(negedge clk_sys)
      if (we === 1'b1)
      begin
         chk(sram_addr, wr_cnt);
         chk(sram_data, shadow[sram_addr]);
         wr_cnt++;
      end

   task automatic do_reset;
      int n;
      @(negedge clk_sys) rst_n = 1'b0;
      repeat (16) @(negedge clk_sys);
      chk(sec_word, 32'hFFFFFFA3);
      chk({ready, oe_n, grant}, 3'b010);
      wr_cnt = 0;
      rst_n = 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 3000)
      begin
         @(negedge clk_sys);
         n++;
      end
      // the last preload word still stands in the first booted cycle
      @(negedge clk_sys);
      chk(ready, 1'b1);
      chk(wr_cnt, OTP_SECTORS * OTP_ROWS - 1);
   endtask

   // strobe is left high so back-to-back words need no gap
   task automatic prog_word(input logic [15:0] a, input logic [31:0] d,
      input logic [1:0] c, input logic refuse);
      prog = '{addr: a, data: d, ctrl: {14'h0000, c}};
      strobe = 1'b1;
      exp_q.push_back(refuse);
      if (refuse === 1'b0)
         shadow[a[OTP_ADDR_W-1:0]] = d;
      @(negedge clk_sys);
   endtask

   task automatic sync_try(input logic on);
      @(negedge clk_sys) out_mode = 1'b1;
      chk(oe_n, 1'b1);
      bp = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(oe_n, !on);
      chk(sync_out, 1'b0);
      {bp, out_mode, in_mode, ext_low} = 4'b0011;
      repeat (5) @(negedge clk_sys);
      chk(dbg, on);
      {in_mode, ext_low} = 2'b00;
   endtask

   // ====
   // main sequence
   initial
   begin
      void'($urandom(89204));
      word_a = ($urandom() & ~32'h00007A03) | 32'h000005A0;
      word_b = word_a | 32'h00007003;
      do_reset();
      // a blank part loads an all-zero word, so the first write is taken
      prog_word({5'h00, OTP_SEC_ROW}, word_a, 2'b11, 1'b0);
      strobe = 1'b0;
      do_reset();
      chk(sec_word, word_a & SEC_DEFINED_MASK);
      chk(gp, word_a[21:15]);
      chk({boot_otp, redun}, 2'b11);
      for (int s = 0; s < 4; s++)
         prog_word({5'h00, s[1:0], 9'(s * 7)}, $urandom(), 2'b01, !s[0]);
      prog_word({5'h00, OTP_SEC_ROW}, word_b, 2'b11, 1'b0);
      strobe = 1'b0;
      link_req = 1'b1;
      @(negedge clk_sys);
      chk(grant, 1'b1);
      sync_try(1'b1);
      probe.scan(IR_DEVICE_IDENTIFICATION, rd);
      chk(rd, {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
      probe.scan(IR_USERCODE, rd);
      chk(rd, {word_a[31:22], 18'h00000, SI_REVISION});
      probe.scan(IR_OTP_ACCESS, rd);
      chk(rd, word_a & SEC_DEFINED_MASK);
      probe.scan(IR_TILE, rd);
      chk(tile_sel, 1'b1);
      $display("open word tests done");
      do_reset();
      chk(sec_word, word_b & SEC_DEFINED_MASK);
      prog_word(16'h0600, $urandom(), 2'b01, 1'b1);
      prog_word({5'h00, OTP_SEC_ROW}, 32'h00000000, 2'b11, 1'b1);
      strobe = 1'b0;
      @(negedge clk_sys);
      chk(grant, 1'b0);
      sync_try(1'b0);
      probe.scan(IR_OTP_ACCESS, rd);
      chk(rd, 32'h00000000);
      probe.scan(IR_TILE, rd);
      chk(tile_sel, 1'b0);
      $display("locked word tests done");
      complete_run();
   end

   // the run needs some 10k cycles; give it ample room
   initial
   begin
      #1000000;
      err_count++;
      complete_run();
   end
endmodule
